// ### shared/tpg_pkg.sv
// Purpose: constants for the twelve-pin general-purpose port
// Assumes: register port is a simple strobed address/data port, 16-bit words
// Notes:   register map below
package tpg_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  ADDR_PIN_DIRECTION      = 8'h33;
  localparam logic [7:0]  ADDR_PIN_OUTPUT_VALUE   = 8'h34;
  localparam logic [7:0]  ADDR_PIN_LEVEL_READBACK = 8'h35;
  localparam int          PIN_COUNT               = 12;
  localparam int          REG_WIDTH               = 16;
  localparam logic [15:0] RST_PIN_DIRECTION       = 16'h0000;
  localparam logic [15:0] RST_PIN_OUTPUT_VALUE    = 16'h0000;
  localparam logic [11:0] RST_PIN_SYNC            = 12'h000;
endpackage : tpg_pkg

// ### src/tpg_gpio_port.sv
// Purpose: twelve general-purpose pins with direction, output and readback registers
// Assumes: register port: i_reg_wr / i_reg_rd one-cycle strobes with address and data
// Notes:   read data is registered, valid the cycle after i_reg_rd
`timescale 1ns/100ps
module tpg_gpio_port (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  input  wire logic [11:0] i_pin,
  output logic      [11:0] o_pin,
  output logic      [11:0] o_pin_oe_n
);
  logic [11:0] pin_direction_q;
  logic [11:0] pin_output_value_q;
  logic [11:0] pin_level_ext;
  logic [11:0] readback;
  logic [15:0] rdata_q;
  logic        rvalid_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // only bits 11..0 are stored, so reserved bits cannot gain a function
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_direction_q <= tpg_pkg::RST_PIN_DIRECTION[11:0];
    end else if (i_reg_wr && hit(i_reg_addr, tpg_pkg::ADDR_PIN_DIRECTION)) begin
      pin_direction_q <= i_reg_wdata[11:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_output_value_q <= tpg_pkg::RST_PIN_OUTPUT_VALUE[11:0];
    end else if (i_reg_wr && hit(i_reg_addr, tpg_pkg::ADDR_PIN_OUTPUT_VALUE)) begin
      pin_output_value_q <= i_reg_wdata[11:0];
    end
  end
  // writes to the readback address fall through both decodes above

  // ----------------------------------------
  // pins
  // ----------------------------------------
  tpg_pin_sync u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_pin),
    .o_level   (pin_level_ext)
  );

  genvar g;
  generate
    for (g = 0; g < tpg_pkg::PIN_COUNT; g++) begin : g_pin
      // input pins: driver off, stored bit masked
      assign o_pin_oe_n[g] = ~pin_direction_q[g];
      assign o_pin[g]      = pin_direction_q[g] & pin_output_value_q[g];
      // output pins read back their stored bit, not the wire
      assign readback[g]   = pin_direction_q[g] ? pin_output_value_q[g] : pin_level_ext[g];
    end
  endgenerate

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        tpg_pkg::ADDR_PIN_DIRECTION:      rdata_q <= {4'h0, pin_direction_q};
        tpg_pkg::ADDR_PIN_OUTPUT_VALUE:   rdata_q <= {4'h0, pin_output_value_q};
        tpg_pkg::ADDR_PIN_LEVEL_READBACK: rdata_q <= {4'h0, readback};
        default:                          rdata_q <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg_rd;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_input_hiz: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    &o_pin_oe_n[11:0] |-> (o_pin == 12'h000)) else $error("input pin driven");
  a_in_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((o_pin & ~pin_direction_q) == 12'h000)) else $error("input pin drive not masked");
  a_dir_write_oe: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_wr && i_reg_addr == tpg_pkg::ADDR_PIN_DIRECTION) |=>
      (o_pin_oe_n == ~$past(i_reg_wdata[11:0])))
    else $error("oe does not follow direction write");
  a_out_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((~o_pin_oe_n) & (o_pin ^ pin_output_value_q)) == 12'h000) else $error("drive mismatch");
  a_rb_output: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == tpg_pkg::ADDR_PIN_LEVEL_READBACK) |=>
      ((o_reg_rdata[11:0] & $past(pin_direction_q)) ==
       ($past(pin_output_value_q) & $past(pin_direction_q)))) else $error("readback wrong");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_reg_rvalid |-> (o_reg_rdata[15:12] == 4'h0)) else $error("reserved bits set");
  // checked at the first edge after release; the first edge of all has no history
  a_dir_reset: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> (o_pin_oe_n == 12'hfff)) else $error("direction not reset");
  a_out_reset: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> (pin_output_value_q == 12'h000)) else $error("output not reset");
  a_ro_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_wr && i_reg_addr == tpg_pkg::ADDR_PIN_LEVEL_READBACK) |=> ($stable(pin_direction_q) &&
      $stable(pin_output_value_q))) else $error("readback write had effect");
  a_in_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == tpg_pkg::ADDR_PIN_LEVEL_READBACK &&
     pin_direction_q == 12'h000) |=>
      (o_reg_rdata[11:0] == $past(pin_level_ext))) else $error("input level wrong");
endmodule : tpg_gpio_port

// ### src/tpg_pin_sync.sv
// Purpose: three-stage synchroniser for the twelve pin inputs
// Assumes: pins are asynchronous to i_clk
// Notes:   a change is accepted once stages two and three agree
`timescale 1ns/100ps
module tpg_pin_sync (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [11:0] i_pin,
  output logic      [11:0] o_level
);
  logic [11:0] meta_q;
  logic [11:0] s2_q;
  logic [11:0] s3_q;
  logic [11:0] level_q;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= tpg_pkg::RST_PIN_SYNC;
      s2_q   <= tpg_pkg::RST_PIN_SYNC;
      s3_q   <= tpg_pkg::RST_PIN_SYNC;
    end else begin
      meta_q <= i_pin;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // per-bit agreement filter; meta_q feeds nothing else
  genvar g;
  generate
    for (g = 0; g < tpg_pkg::PIN_COUNT; g++) begin : g_agree
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          level_q[g] <= tpg_pkg::RST_PIN_SYNC[g];
        end else if (s2_q[g] == s3_q[g]) begin
          level_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign o_level = level_q;
endmodule : tpg_pin_sync

// ### verification/test_tpg_gpio_port.sv
// Purpose: self-checking bench for the twelve-pin port
// Assumes: pin levels settle within five cycles
// Notes:   random direction, output and board levels, fixed seed
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module test_tpg_gpio_port;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic        o_reg_rvalid;
  logic [11:0] ext = 12'h000;
  logic [11:0] i_pin, o_pin, o_pin_oe_n;
  logic [15:0] dir, out;
  int          n_mismatch = 0;
  int          checks = 0;
  integer      seed = 32'hcd09ffad;
  always #2.5 i_clk = ~i_clk;
  tpg_gpio_port DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_pin(i_pin),
    .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));
  tpg_board board (.i_ext(ext), .i_drv(o_pin), .i_oe_n(o_pin_oe_n), .o_wire(i_pin));
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [15:0] exp_lvl(input logic [15:0] d, o, input logic [11:0] e);
    return {4'h0, (o[11:0] & d[11:0]) | (e & ~d[11:0])};
  endfunction : exp_lvl
  // one access; a read compares against v
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    #1;
    i_reg_wr    = w;
    i_reg_rd    = ~w;
    i_reg_addr  = a;
    i_reg_wdata = v;
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    if (!w) begin
      `CHK(o_reg_rvalid, 1'b1)
      `CHK(o_reg_rdata, v)
    end
  endtask : acc
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    `CHK(o_pin_oe_n, 12'hfff)
    acc(1'b0, 8'h33, 16'h0000);
    acc(1'b0, 8'h34, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      // first two passes: all outputs, then all inputs with every drive bit set
      dir = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
      out = (k == 1) ? 16'hffff : 16'($random(seed));
      ext = 12'($random(seed));
      acc(1'b1, 8'h33, dir);
      acc(1'b1, 8'h34, out);
      acc(1'b1, 8'h35, ~exp_lvl(dir, out, ext));
      repeat (5) @(posedge i_clk);
      `CHK(o_pin_oe_n, ~dir[11:0])
      `CHK(o_pin, out[11:0] & dir[11:0])
      acc(1'b0, 8'h33, {4'h0, dir[11:0]});
      acc(1'b0, 8'h34, {4'h0, out[11:0]});
      acc(1'b0, 8'h35, exp_lvl(dir, out, ext));
      acc(1'b0, 8'h36, 16'h0000);
    end
    // second reset while the registers hold random values
    @(posedge i_clk);
    #1;
    i_sys_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    `CHK(o_pin_oe_n, 12'hfff)
    `CHK(o_pin, 12'h000)
    acc(1'b0, 8'h33, 16'h0000);
    acc(1'b0, 8'h34, 16'h0000);
    test_done();
  end
  // generous: the sequence needs under 5 us
  initial begin
    #50000;
    n_mismatch++;
    test_done();
  end
endmodule : test_tpg_gpio_port

// ### verification/tpg_board.sv
// Purpose: board-level model of the twelve pin wires
// Assumes: board drives every pin the device has released
// Notes:   a driven pin shows the device level on the wire
`timescale 1ns/100ps
module tpg_board (
  input  wire logic [11:0] i_ext,
  input  wire logic [11:0] i_drv,
  input  wire logic [11:0] i_oe_n,
  output logic      [11:0] o_wire
);
  // no contention modelled: board yields where the device drives
  assign o_wire = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule : tpg_board
